// ===== ewp_host_ctrl.sv
// Host-side controller that writes, reads and locks a byte-wide EEPROM.
// Assumes the EEPROM pins are wired straight to the outputs below.
//
// Notes on behaviour
// R1 - EEPROM latches address on last falling strobe.
// R2 - EEPROM latches data on first rising strobe.
// R3 - EEPROM filters control glitches of 20 ns.
// R4 - Host strobes only for intended accesses.
// R5 - Host keeps strobes inactive while unstable.
// R6 - Host holds inhibit low during reset.
// R7 - EEPROM aborts programming when inhibit falls.
// R8 - Inhibit stays high 10 ms after data.
// R9 - Lock needs prefix plus data byte.
// R10 - Prefix alone does not lock.
// R11 - Locked writes each get the prefix.
// R12 - Six-byte sequence clears the lock.
// R13 - Unlock sequence programs no data.
// R14 - Factory state is unlocked.
// R15 - Lock prefix is 5555/AA 2AAA/55 5555/A0.
// R16 - Sequence bytes follow within 30 us.
// R17 - Programming starts 100 us after last byte.
// R18 - No access while inhibit is low.
// R19 - Busy reads return complemented top bit.
`timescale 1ns/1ns
module ewp_host_ctrl
  import ewp_pkg::*;
#(
  parameter int unsigned RECOVER_CYC = RP_CYC,
  parameter int unsigned COMMIT_CYC = BL_CYC + WC_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic [1:0] cmd_in,
  input wire logic [14:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic lock_strap_in,
  output logic ready_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic lock_active_out,
  output logic [14:0] mem_addr_out,
  output logic [7:0] mem_data_out,
  output logic mem_data_oe_out,
  input wire logic [7:0] mem_data_in,
  output logic chip_sel_n_out,
  output logic out_gate_n_out,
  output logic write_strobe_n_out,
  output logic write_inhibit_n_out
);

  if (RECOVER_CYC < 1 || COMMIT_CYC < 1 || COMMIT_CYC >= 2 ** (CNT_W - 1)) begin : g_bad
    $error("ewp_host_ctrl: wait counts must be at least one cycle and fit the counter");
  end

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_RECOVER = 3'h0,
    ST_IDLE = 3'h1,
    ST_ISSUE = 3'h3,
    ST_CYCLE = 3'h2,
    ST_COMMIT = 3'h6
  } ewp_state_e;

  ewp_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  ewp_cmd_e cmd_q;
  logic [14:0] uaddr_q;
  logic [7:0] udata_q;
  logic [2:0] step_q;
  logic [2:0] last_q;
  logic [2:0] pre_q;
  logic lock_q;
  logic ready_q;
  logic done_q;
  logic [7:0] rdata_q;
  logic inhibit_n_q;
  logic [22:0] step_word;
  logic step_done;

  ewp_cycle_if cyc_bus ();

  ewp_bus_cycle u_cycle (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .cyc(cyc_bus),
    .mem_addr_out(mem_addr_out),
    .mem_data_out(mem_data_out),
    .mem_data_oe_out(mem_data_oe_out),
    .mem_data_in(mem_data_in),
    .chip_sel_n_out(chip_sel_n_out),
    .out_gate_n_out(out_gate_n_out),
    .write_strobe_n_out(write_strobe_n_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Table steps come first; the user byte, if any, closes the sequence.
  always_comb begin
    step_word = {uaddr_q, udata_q};
    if (step_q < pre_q) begin
      step_word = ewp_seq_word(cmd_q == CMD_UNLOCK, step_q); // [R12] [R15]
    end
  end

  assign step_done = cyc_bus.done && (step_q == last_q);

  //////////////////////////////////////////////////////////////////////////////
  // Inhibit drops only during reset, so only a reset can cut programming short. [R6] [R7] [R8]
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      inhibit_n_q <= 1'b0; // [R6]
    end else begin
      inhibit_n_q <= 1'b1;
    end
  end

  assign write_inhibit_n_out = inhibit_n_q;

  //////////////////////////////////////////////////////////////////////////////
  // The lock state lives in the EEPROM across power cycles, so it is only
  // guessed here: the strap gives its start value, commands then track it.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      lock_q <= 1'b0; // [R14]
    end else if (state_q == ST_RECOVER && cnt_q == CNT_W'(RECOVER_CYC - 1)) begin
      lock_q <= lock_strap_in;
    end else if (step_done && cmd_q == CMD_LOCK) begin
      lock_q <= 1'b1; // [R9]
    end else if (step_done && cmd_q == CMD_UNLOCK) begin
      lock_q <= 1'b0; // [R12]
    end
  end

  assign lock_active_out = lock_q;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= ST_RECOVER;
      cnt_q <= '0;
      cmd_q <= CMD_READ;
      uaddr_q <= 15'h0000;
      udata_q <= 8'h00;
      step_q <= 3'h0;
      last_q <= 3'h0;
      pre_q <= 3'h0;
      cyc_bus.start <= 1'b0;
      cyc_bus.wr <= 1'b0;
      cyc_bus.addr <= 15'h0000;
      cyc_bus.wdata <= 8'h00;
    end else begin
      cyc_bus.start <= 1'b0;
      case (state_q)
        ST_RECOVER: begin
          // No access until inhibit has been high for the protect time. [R5] [R18]
          if (cnt_q == CNT_W'(RECOVER_CYC - 1)) begin
            cnt_q <= '0;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_IDLE: begin
          if (req_in) begin
            cmd_q <= ewp_cmd_e'(cmd_in);
            uaddr_q <= addr_in;
            udata_q <= wdata_in;
            step_q <= 3'h0;
            case (ewp_cmd_e'(cmd_in))
              CMD_WRITE: begin
                pre_q <= lock_q ? LOCK_PRE_STEPS : 3'h0; // [R11]
                last_q <= lock_q ? LOCK_PRE_STEPS : 3'h0; // [R11]
              end
              CMD_LOCK: begin
                pre_q <= LOCK_PRE_STEPS;
                last_q <= LOCK_PRE_STEPS; // [R9] [R10]
              end
              CMD_UNLOCK: begin
                pre_q <= UNLOCK_STEPS; // [R13]
                last_q <= UNLOCK_STEPS - 3'h1;
              end
              default: begin
                pre_q <= 3'h0;
                last_q <= 3'h0;
              end
            endcase
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          cyc_bus.start <= 1'b1;
          cyc_bus.wr <= (cmd_q != CMD_READ);
          cyc_bus.addr <= step_word[22:8];
          cyc_bus.wdata <= step_word[7:0];
          state_q <= ST_CYCLE;
        end
        ST_CYCLE: begin
          // Bytes of a sequence go back to back, far inside the load window. [R16]
          if (cyc_bus.done) begin
            if (step_q != last_q) begin
              step_q <= step_q + 3'h1;
              state_q <= ST_ISSUE;
            end else if (cmd_q == CMD_READ) begin
              state_q <= ST_IDLE;
            end else begin
              cnt_q <= '0;
              state_q <= ST_COMMIT;
            end
          end
        end
        default: begin
          // Wait out the load window and the full write cycle instead of
          // polling, which keeps busy reads off the bus. [R17] [R8] [R19]
          if (cnt_q == CNT_W'(COMMIT_CYC - 1)) begin
            cnt_q <= '0;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ready_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      if (state_q == ST_IDLE && req_in) begin
        ready_q <= 1'b0;
      end else if (state_q == ST_RECOVER && cnt_q == CNT_W'(RECOVER_CYC - 1)) begin
        ready_q <= 1'b1;
      end else if (step_done && cmd_q == CMD_READ) begin
        ready_q <= 1'b1;
        done_q <= 1'b1;
        rdata_q <= cyc_bus.rdata;
      end else if (state_q == ST_COMMIT && cnt_q == CNT_W'(COMMIT_CYC - 1)) begin
        ready_q <= 1'b1;
        done_q <= 1'b1;
      end
    end
  end

  assign ready_out = ready_q;
  assign done_out = done_q;
  assign rdata_out = rdata_q;

endmodule : ewp_host_ctrl

// ===== ewp_pkg.sv
// Constants, command codes and lock sequence table for the EEPROM write controller.
// Assumes a 250 MHz controller clock and a byte-wide EEPROM with a 15-bit address.
package ewp_pkg;

  //////////////////////////////////////////////////////////////////////////////
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Least times round up to whole cycles.
  localparam int unsigned WP_NS = 100;
  localparam int unsigned WP_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACC_NS = 100;
  localparam int unsigned ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned AH_NS = 50;
  localparam int unsigned AH_CYC = (AH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLC_MIN_NS = 200;
  localparam int unsigned BLC_CYC = (BLC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REC_CYC = (BLC_CYC > WP_CYC + 1 + AH_CYC) ?
                                    (BLC_CYC - WP_CYC - 1) : AH_CYC;
  localparam int unsigned BL_US = 100;
  localparam int unsigned BL_CYC = BL_US * CLK_MHZ;
  localparam int unsigned WC_MS = 10;
  localparam int unsigned WC_CYC = WC_MS * 1000 * CLK_MHZ;
  localparam int unsigned RP_US = 100;
  localparam int unsigned RP_CYC = RP_US * CLK_MHZ;
  localparam int unsigned CNT_W = 32;

  //////////////////////////////////////////////////////////////////////////////
  localparam logic [14:0] CMD_ADDR_A = 15'h5555;
  localparam logic [14:0] CMD_ADDR_B = 15'h2AAA;
  localparam logic [7:0] CODE_AA = 8'hAA;
  localparam logic [7:0] CODE_55 = 8'h55;
  localparam logic [7:0] CODE_LOCK = 8'hA0;
  localparam logic [7:0] CODE_80 = 8'h80;
  localparam logic [7:0] CODE_UNLOCK = 8'h20;
  localparam logic [2:0] LOCK_PRE_STEPS = 3'h3;
  localparam logic [2:0] UNLOCK_STEPS = 3'h6;

  typedef enum logic [1:0] {
    CMD_READ = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_LOCK = 2'h2,
    CMD_UNLOCK = 2'h3
  } ewp_cmd_e;

  // Returns {address, data} of step k of the lock prefix or the unlock sequence.
  function automatic logic [22:0] ewp_seq_word(input logic unlock, input logic [2:0] k);
    logic [22:0] w;
    w = {CMD_ADDR_A, CODE_AA};
    case (k)
      3'h0: w = {CMD_ADDR_A, CODE_AA};
      3'h1: w = {CMD_ADDR_B, CODE_55};
      3'h2: w = unlock ? {CMD_ADDR_A, CODE_80} : {CMD_ADDR_A, CODE_LOCK};
      3'h3: w = {CMD_ADDR_A, CODE_AA};
      3'h4: w = {CMD_ADDR_B, CODE_55};
      default: w = {CMD_ADDR_A, CODE_UNLOCK};
    endcase
    return w;
  endfunction : ewp_seq_word

endpackage : ewp_pkg

// ===== ewp_cycle_if.sv
// Interface between the sequencer and the bus cycle engine.
// Assumes one clock domain; start is a one-cycle pulse, done answers it.
`timescale 1ns/1ns
interface ewp_cycle_if;
  logic start;
  logic wr;
  logic [14:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;

  modport seq (output start, output wr, output addr, output wdata,
               input done, input rdata);
  modport engine (input start, input wr, input addr, input wdata,
                  output done, output rdata);
endinterface : ewp_cycle_if

// ===== ewp_bus_cycle.sv
// Bus cycle engine: one strobed write or read on the EEPROM pins.
// Assumes start comes only while idle; all pin outputs are registered.
`timescale 1ns/1ns
module ewp_bus_cycle
  import ewp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  ewp_cycle_if.engine cyc,
  output logic [14:0] mem_addr_out,
  output logic [7:0] mem_data_out,
  output logic mem_data_oe_out,
  input wire logic [7:0] mem_data_in,
  output logic chip_sel_n_out,
  output logic out_gate_n_out,
  output logic write_strobe_n_out
);

  typedef enum logic [1:0] {
    E_IDLE = 2'h0,
    E_SETUP = 2'h1,
    E_PULSE = 2'h3,
    E_REC = 2'h2
  } ewp_eng_e;

  ewp_eng_e state_q;
  logic [7:0] cnt_q;
  logic wr_q;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= E_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      cyc.done <= 1'b0;
      cyc.rdata <= 8'h00;
      mem_addr_out <= 15'h0000;
      mem_data_out <= 8'h00;
      mem_data_oe_out <= 1'b0;
      chip_sel_n_out <= 1'b1;
      out_gate_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
    end else begin
      cyc.done <= 1'b0;
      case (state_q)
        E_IDLE: begin
          if (cyc.start) begin
            wr_q <= cyc.wr;
            mem_addr_out <= cyc.addr;
            mem_data_out <= cyc.wdata;
            mem_data_oe_out <= cyc.wr;
            chip_sel_n_out <= 1'b0;
            state_q <= E_SETUP;
          end
        end
        E_SETUP: begin
          // Strobe widths of 100 ns keep every access well clear of the glitch filter. [R4]
          if (wr_q) begin
            write_strobe_n_out <= 1'b0;
            cnt_q <= 8'(WP_CYC - 1);
          end else begin
            out_gate_n_out <= 1'b0;
            cnt_q <= 8'(ACC_CYC - 1);
          end
          state_q <= E_PULSE;
        end
        E_PULSE: begin
          if (cnt_q == 8'h00) begin
            if (!wr_q) begin
              cyc.rdata <= mem_data_in;
            end
            write_strobe_n_out <= 1'b1;
            out_gate_n_out <= 1'b1;
            chip_sel_n_out <= 1'b1;
            cnt_q <= 8'(REC_CYC - 1);
            state_q <= E_REC;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          // Address and data stay driven through recovery to cover hold time.
          if (cnt_q == 8'h00) begin
            mem_data_oe_out <= 1'b0;
            cyc.done <= 1'b1;
            state_q <= E_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
      endcase
    end
  end

endmodule : ewp_bus_cycle

// ===== ewp_host_ctrl_checker.sv
// Concurrent checks on the pins of the EEPROM write controller.
// Assumes the controller top ports only; bound in at the foot of this file.
`timescale 1ns/1ns
module ewp_host_ctrl_checker
  import ewp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [14:0] mem_addr_out,
  input wire logic [7:0] mem_data_out,
  input wire logic mem_data_oe_out,
  input wire logic chip_sel_n_out,
  input wire logic out_gate_n_out,
  input wire logic write_strobe_n_out,
  input wire logic write_inhibit_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  //////////////////////////////////////////////////////////////////////////////
  // Counts strobe-low cycles so the pulse width can be judged when it ends.
  logic [7:0] low_cnt_q;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || write_strobe_n_out) begin
      low_cnt_q <= 8'h00;
    end else begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // A release right after reset is the reset forcing the pin, not a real strobe.
  sequence s_we_release;
    $rose(write_strobe_n_out) && !$past(rst_in);
  endsequence

  property p_inhibit_in_reset;
    disable iff (1'b0) rst_in |=> !write_inhibit_n_out;
  endproperty
  a_inhibit_in_reset: assert property (p_inhibit_in_reset)
    else $error("protect pin not low in reset");
  property p_inhibit_after;
    !rst_in |=> write_inhibit_n_out;
  endproperty
  a_inhibit_after: assert property (p_inhibit_after)
    else $error("protect pin dropped outside reset");
  property p_quiet_in_reset;
    disable iff (1'b0) rst_in |=> chip_sel_n_out && write_strobe_n_out && out_gate_n_out
      && !mem_data_oe_out;
  endproperty
  a_quiet_in_reset: assert property (p_quiet_in_reset)
    else $error("control pins active in reset");
  property p_we_pulse;
    s_we_release |-> low_cnt_q == 8'(WP_CYC);
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("write strobe width wrong");
  property p_ce_covers_we;
    !write_strobe_n_out |-> !chip_sel_n_out && out_gate_n_out && mem_data_oe_out;
  endproperty
  a_ce_covers_we: assert property (p_ce_covers_we)
    else $error("strobe without select or data");
  property p_setup_stable;
    !write_strobe_n_out |-> $stable(mem_addr_out) && $stable(mem_data_out);
  endproperty
  a_setup_stable: assert property (p_setup_stable)
    else $error("address or data moved under strobe");
  property p_hold_after;
    s_we_release |-> mem_data_oe_out ##1 ($stable(mem_data_out) && $stable(mem_addr_out))[*8];
  endproperty
  a_hold_after: assert property (p_hold_after)
    else $error("data not held after strobe");
  property p_gap;
    s_we_release |=> write_strobe_n_out[*8];
  endproperty
  a_gap: assert property (p_gap)
    else $error("strobes too close");
  property p_read_quiet;
    !out_gate_n_out |-> write_strobe_n_out && !mem_data_oe_out && !chip_sel_n_out;
  endproperty
  a_read_quiet: assert property (p_read_quiet)
    else $error("read overlaps write");
endmodule : ewp_host_ctrl_checker

bind ewp_host_ctrl ewp_host_ctrl_checker u_chk (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .mem_addr_out(mem_addr_out),
  .mem_data_out(mem_data_out),
  .mem_data_oe_out(mem_data_oe_out),
  .chip_sel_n_out(chip_sel_n_out),
  .out_gate_n_out(out_gate_n_out),
  .write_strobe_n_out(write_strobe_n_out),
  .write_inhibit_n_out(write_inhibit_n_out)
);

// ===== ewp_eeprom_model.sv
// Behavioural byte-wide EEPROM with write lock, glitch filter and protect pin.
// Assumes host pins straight in; bus_out is the resolved data line level.
`timescale 1ns/1ns
module ewp_eeprom_model #(
  parameter int WRITE_NS = 100
) (
  input wire logic [14:0] addr_in,
  input wire logic [7:0] host_data_in,
  input wire logic host_oe_in,
  input wire logic chip_sel_n_in,
  input wire logic out_gate_n_in,
  input wire logic write_strobe_n_in,
  input wire logic write_inhibit_n_in,
  output logic [7:0] bus_out,
  output logic locked_out
);
  logic [7:0] mem [0:32767];
  logic [14:0] la;
  logic [14:0] pa;
  logic [7:0] pd;
  logic [7:0] flt = 8'h5A;
  logic busy = 1'b0;
  logic pfx = 1'b0;
  int st = 0;
  time t_fall = 0;
  wire strobe_n = chip_sel_n_in | write_strobe_n_in;
  wire rd_en = !chip_sel_n_in && !out_gate_n_in && write_inhibit_n_in;

  initial begin
    locked_out = 1'b0;
    for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
  end
  // A released line must not look like held data.
  always #3 flt = ~flt;

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic step_ok(input int s, input logic [14:0] a, input logic [7:0] d);
    case (s)
      0, 3: return a == 15'h5555 && d == 8'hAA;
      1, 4: return a == 15'h2AAA && d == 8'h55;
      2: return a == 15'h5555 && (d == 8'h80 || d == 8'hA0);
      default: return a == 15'h5555 && d == 8'h20;
    endcase
  endfunction : step_ok

  task automatic start_write(input logic [14:0] a, input logic [7:0] d);
    pa = a;
    pd = d;
    busy = 1'b1;
    fork
      begin
        // The load window and the write time are folded into one short delay.
        #(WRITE_NS);
        if (busy) begin
          mem[pa] = pd;
          busy = 1'b0;
        end
      end
    join_none
  endtask : start_write

  task automatic accept(input logic [14:0] a, input logic [7:0] d);
    if (st == 3 && pfx) begin
      locked_out = 1'b1;
      start_write(a, d);
      st = 0;
      pfx = 1'b0;
    end else if (step_ok(st, a, d)) begin
      if (st == 2) pfx = (d == 8'hA0);
      st = (st == 5) ? 0 : st + 1;
      if (st == 0) locked_out = 1'b0;
    end else begin
      if (!locked_out) start_write(a, d);
      st = 0;
      pfx = 1'b0;
    end
  endtask : accept

  //////////////////////////////////////////////////////////////////////////////
  always @(negedge strobe_n) begin
    la = addr_in;
    t_fall = $time;
  end
  always @(posedge strobe_n) begin
    if (write_inhibit_n_in === 1'b1 && ($time - t_fall) > 20) accept(la, host_data_in);
  end
  always @(negedge write_inhibit_n_in) begin
    if (busy) begin
      mem[pa] = ~pd;
      busy = 1'b0;
    end
  end
  // Only the array path carries access delay, so a released line never keeps old data.
  logic [7:0] rd_dly;
  assign #50 rd_dly = busy ? {~pd[7], pd[6:0]} : mem[addr_in];
  assign bus_out = rd_en ? rd_dly : (host_oe_in ? host_data_in : flt);
endmodule : ewp_eeprom_model

// ===== ewp_host_ctrl_tb.sv
// Self-checking bench for the EEPROM write controller against the EEPROM model.
// Assumes shortened recovery and commit counts; expectations kept in a queue.
`timescale 1ns/1ns
module ewp_host_ctrl_tb;
  import ewp_pkg::*;
  typedef struct {logic rd; logic [7:0] d; logic lk;} ewp_note_s;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_in = 1'b0;
  logic [1:0] cmd_in = 2'h0;
  logic [14:0] addr_in = 15'h0000;
  logic [7:0] wdata_in = 8'h00;
  logic lock_strap_in = 1'b0;
  logic ready_out, done_out, lock_active_out, mem_data_oe_out, model_lock;
  logic chip_sel_n_out, out_gate_n_out, write_strobe_n_out, write_inhibit_n_out;
  logic [7:0] rdata_out, mem_data_out, mem_data_in;
  logic [14:0] mem_addr_out;
  int bad_count = 0;
  int comparisons = 0;
  int seed = 42288;
  logic exp_lock = 1'b0;
  ewp_note_s notes[$];

  always #2 ref_clk_in = ~ref_clk_in;

  ewp_host_ctrl #(.RECOVER_CYC(4), .COMMIT_CYC(8)) dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_in(req_in), .cmd_in(cmd_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .lock_strap_in(lock_strap_in),
    .ready_out(ready_out), .done_out(done_out), .rdata_out(rdata_out),
    .lock_active_out(lock_active_out), .mem_addr_out(mem_addr_out),
    .mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out),
    .mem_data_in(mem_data_in), .chip_sel_n_out(chip_sel_n_out),
    .out_gate_n_out(out_gate_n_out), .write_strobe_n_out(write_strobe_n_out),
    .write_inhibit_n_out(write_inhibit_n_out));
  ewp_eeprom_model #(.WRITE_NS(100)) u_mem (
    .addr_in(mem_addr_out), .host_data_in(mem_data_out), .host_oe_in(mem_data_oe_out),
    .chip_sel_n_in(chip_sel_n_out), .out_gate_n_in(out_gate_n_out),
    .write_strobe_n_in(write_strobe_n_out), .write_inhibit_n_in(write_inhibit_n_out),
    .bus_out(mem_data_in), .locked_out(model_lock));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (!ok) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  // An aborted write never answers, so it leaves no note behind.
  task automatic op(input ewp_cmd_e c, input logic [14:0] a, input logic [7:0] d,
                    input logic abort);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    while (ready_out !== 1'b1 && n < 4000) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (n >= 4000) check(1'b0, "controller never ready");
    @(posedge ref_clk_in);
    req_in <= 1'b1;
    cmd_in <= c;
    addr_in <= a;
    wdata_in <= d;
    if (!abort) notes.push_back('{c == CMD_READ, d, exp_lock});
    @(posedge ref_clk_in);
    req_in <= 1'b0;
    if (abort) begin
      wait (write_strobe_n_out === 1'b0);
      @(posedge write_strobe_n_out);
      @(posedge ref_clk_in);
      rst_in <= 1'b1;
      @(posedge ref_clk_in);
      rst_in <= 1'b0;
    end
  endtask : op

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_in) begin : mon_blk
    ewp_note_s n;
    if (done_out === 1'b1) begin
      if (notes.size() == 0) begin
        check(1'b0, "answer without request");
      end else begin
        n = notes.pop_front();
        if (n.rd) check(rdata_out === n.d, "read data");
        check(lock_active_out === n.lk && model_lock === n.lk, "lock state");
      end
    end
  end

  initial begin
    logic [14:0] a;
    logic [7:0] d;
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      a = (15'($random(seed)) & 15'h1FFF) | 15'h6000;
      d = 8'($random(seed));
      op(CMD_WRITE, a, d, 1'b0);
      op(CMD_READ, a, d, 1'b0);
    end
    exp_lock = 1'b1;
    op(CMD_LOCK, a, 8'h3C, 1'b0);
    op(CMD_READ, a, 8'h3C, 1'b0);
    d = 8'($random(seed));
    op(CMD_WRITE, 15'h6001, d, 1'b0);
    op(CMD_READ, 15'h6001, d, 1'b0);
    exp_lock = 1'b0;
    op(CMD_UNLOCK, 15'h0000, 8'h00, 1'b0);
    op(CMD_READ, 15'h5555, 8'hFF, 1'b0);
    op(CMD_READ, 15'h2AAA, 8'hFF, 1'b0);
    op(CMD_WRITE, 15'h6003, 8'h5A, 1'b0);
    op(CMD_READ, 15'h6003, 8'h5A, 1'b0);
    op(CMD_WRITE, 15'h6002, 8'hC3, 1'b1);
    op(CMD_READ, 15'h6002, 8'h3C, 1'b0);
    while (notes.size() != 0) @(posedge ref_clk_in);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    check(1'b0, "watchdog expired");
    give_verdict();
  end
endmodule : ewp_host_ctrl_tb
